// ---- hdl/dma_slave_channels.v ----
// two independent slave-mode dma channels: port protocol, status and interrupt status
// assumes a synchronous register port and synchronous pins; fifo and counters live outside
//
// Contract
// - single slave: request out, ack marks transaction
// - mode 101 reserved, no transfer behaviour
// - burst slave: request held until fifo full
// - disk mode: request in, ack is go-ahead
// - disk read: withhold go-ahead when exhausted, pipeline empty
// - disk write: go-ahead once started and fifo data
// - disk error: no go-ahead until cleared, restarted
// - bit 0 engaged while transferring
// - start during engaged sets pipeline full; implemented only once the pipeline is loaded
// - bit 2 reports fifo empty
// - bit 3 set during pio or reset
// - bits 4,5 logical request and ack
// - idle interrupt on engaged fall, w1c
// - pipeline free interrupt on fall, w1c
// - parity fault sets flag, finishes block
// - late fault on over/underrun unless paused
// - start while full or faulted is refused
// - pio in slave or busy control write refused
// - pio read parity fault sets bit 6
// - bit 7 ors the five faults
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "dma_chan_defs.vh"

module dma_slave_channels (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [7:0] i_addr, // register byte address
  input wire [7:0] i_wdata, // register write data
  input wire i_wr, // one-cycle write strobe
  input wire i_rd, // one-cycle read strobe
  output reg [7:0] o_rdata, // valid the cycle after i_rd
  input wire [1:0] i_transfer_request_pin, // request pin level per channel (input in disk mode)
  output reg [1:0] o_transfer_request_pin, // request pin drive per channel
  output reg [1:0] o_transfer_request_oe, // high while request pin is an output
  input wire [1:0] i_transfer_ack_pin, // ack pin level per channel (input in plain slave modes)
  output reg [1:0] o_transfer_ack_pin, // go-ahead drive in disk mode
  output reg [1:0] o_transfer_ack_oe, // high while ack pin is an output
  input wire [1:0] i_fifo_full, // channel fifo cannot take a byte
  input wire [1:0] i_fifo_empty, // channel fifo holds no data
  input wire [1:0] i_fifo_overrun, // one-cycle over/underrun event
  input wire [1:0] i_parity_err, // one-cycle data parity event
  input wire [1:0] i_block_end, // one-cycle end of current block
  input wire [1:0] i_count_done, // transfer count exhausted
  input wire [1:0] i_disk_read, // formatter reading the disk
  input wire [1:0] i_pio_req, // one-cycle programmed i/o request
  input wire [1:0] i_pio_done, // one-cycle programmed i/o completion
  input wire [1:0] i_pio_parity, // one-cycle pio read parity event
  output reg [1:0] o_pio_grant, // pulse: pio accepted
  output reg [1:0] o_pipe_discard // pulse: pipelined transfer dropped
);

  // per-channel state, index 0 = channel a, 1 = channel b
  reg [7:0] control_reg [0:1]; // firmware control
  reg [6:0] irq_reg [0:1]; // sticky interrupt bits 0..6
  reg [1:0] engaged_reg; // transfer in progress
  reg [1:0] pipe_full_reg; // next transfer pipelined
  reg [1:0] pipe_loaded_reg; // pipeline registers written
  reg [1:0] pipe_bad_reg; // pipelined transfer must be dropped
  reg [1:0] halt_reg; // parity fault: stop after block
  reg [1:0] port_pending_reg; // pio in flight
  reg [1:0] reset_busy_reg; // channel reset in progress
  reg [1:0] goahead_reg; // disk go-ahead issued for current request
  reg [1:0] req_seen_reg; // previous logical disk request
  // each process keeps its own loop index so no variable has two drivers
  integer ch; // channel index of the state process
  integer cc; // channel index of the combinational decode
  integer cp; // channel index of the pin process

  // logical request: polarity bit inverts the raw pin
  function logical_req;
    input raw;
    input pol;
    begin
      logical_req = raw ^ pol;
    end
  endfunction

  // fault summary over the five error bits
  function any_fault;
    input [6:0] f;
    begin
      any_fault = f[`IS_PARITY] | f[`IS_LATE] | f[`IS_START_REF] | f[`IS_PIO_REF] |
                  f[`IS_PIO_PAR];
    end
  endfunction

  // status byte assembled from live state
  function [7:0] status_byte;
    input eng;
    input pf;
    input vac;
    input pnd;
    input rq;
    input ak;
    begin
      status_byte = {2'b00, ak, rq, pnd, vac, pf, eng};
    end
  endfunction

  // decoded write strobes per channel
  reg [1:0] wr_ctl;
  reg [1:0] wr_cmd;
  reg [1:0] wr_irq;
  always @* begin
    wr_ctl = 2'b00;
    wr_cmd = 2'b00;
    wr_irq = 2'b00;
    if (i_wr && i_addr == `A_CONTROL_ADDR) begin
      wr_ctl[0] = 1'b1;
    end else if (i_wr && i_addr == `A_PIPE_ADDR) begin
      wr_cmd[0] = 1'b1;
    end else if (i_wr && i_addr == `A_IRQ_STATUS_ADDR) begin
      wr_irq[0] = 1'b1;
    end else if (i_wr && i_addr == `B_CONTROL_ADDR) begin
      wr_ctl[1] = 1'b1;
    end else if (i_wr && i_addr == `B_PIPE_ADDR) begin
      wr_cmd[1] = 1'b1;
    end else if (i_wr && i_addr == `B_IRQ_STATUS_ADDR) begin
      wr_irq[1] = 1'b1;
    end
  end

  // per-channel event terms, computed combinationally then registered below
  reg [1:0] start_ok;
  reg [1:0] start_bad;
  reg [1:0] pio_bad;
  reg [1:0] ctl_bad;
  reg [1:0] is_slave;
  reg [1:0] disk_mode;
  reg [1:0] lreq;
  reg [1:0] ack_state;
  reg [1:0] gate;
  reg [2:0] mode;
  always @* begin
    start_ok = 2'b00;
    start_bad = 2'b00;
    pio_bad = 2'b00;
    ctl_bad = 2'b00;
    is_slave = 2'b00;
    disk_mode = 2'b00;
    lreq = 2'b00;
    ack_state = 2'b00;
    gate = 2'b00;
    mode = 3'h0;
    for (cc = 0; cc < 2; cc = cc + 1) begin
      mode = control_reg[cc][`CTL_MODE_HI:`CTL_MODE_LO];
      is_slave[cc] = mode[2];
      disk_mode[cc] = (mode == `MODE_DISK_SLAVE);
      lreq[cc] = logical_req(i_transfer_request_pin[cc], control_reg[cc][`CTL_REQ_POL]);
      // start refused when pipeline full or a fault stands uncleared
      if (wr_cmd[cc] && i_wdata[`CMD_START]) begin
        if (pipe_full_reg[cc] || any_fault(irq_reg[cc])) begin
          start_bad[cc] = 1'b1;
        end else begin
          start_ok[cc] = 1'b1;
        end
      end
      // pio is refused in any slave mode (mode bit 2 set)
      pio_bad[cc] = i_pio_req[cc] & is_slave[cc];
      ctl_bad[cc] = wr_ctl[cc] & engaged_reg[cc];
      // ack pin is an input in plain slave modes, our go-ahead in disk mode
      ack_state[cc] = disk_mode[cc] ? goahead_reg[cc] : i_transfer_ack_pin[cc];
      // disk go-ahead conditions
      if (halt_reg[cc] || any_fault(irq_reg[cc])) begin
        gate[cc] = 1'b0;
      end else if (i_disk_read[cc]) begin
        // count exhausted with nothing pipelined: hold the formatter off
        gate[cc] = engaged_reg[cc] & ~(i_count_done[cc] & ~pipe_full_reg[cc]);
      end else begin
        // writing the disk needs bytes in the fifo before the next burst
        gate[cc] = engaged_reg[cc] & ~i_fifo_empty[cc];
      end
    end
  end

  // channel state, status and sticky interrupt bits
  // set terms are or-ed after the write-one clear, so an event in the clear cycle survives
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      for (ch = 0; ch < 2; ch = ch + 1) begin
        control_reg[ch] <= `CONTROL_RESET;
        irq_reg[ch] <= 7'h00;
      end
      engaged_reg <= 2'b00;
      pipe_full_reg <= 2'b00;
      pipe_loaded_reg <= 2'b00;
      pipe_bad_reg <= 2'b00;
      halt_reg <= 2'b00;
      port_pending_reg <= 2'b00;
      reset_busy_reg <= 2'b00;
      goahead_reg <= 2'b00;
      req_seen_reg <= 2'b00;
      o_pio_grant <= 2'b00;
      o_pipe_discard <= 2'b00;
    end else begin
      o_pio_grant <= 2'b00;
      o_pipe_discard <= 2'b00;
      for (ch = 0; ch < 2; ch = ch + 1) begin : per_channel
        reg [6:0] nxt;
        reg eng_n;
        reg pf_n;
        nxt = irq_reg[ch];
        eng_n = engaged_reg[ch];
        pf_n = pipe_full_reg[ch];
        // control write only while not engaged; rejected write leaves it unchanged
        if (wr_ctl[ch] && !engaged_reg[ch]) begin
          control_reg[ch] <= i_wdata;
        end
        // pipeline load accepted only while the pipeline is free
        if (wr_cmd[ch] && i_wdata[`CMD_LOAD] && !pipe_full_reg[ch]) begin
          pipe_loaded_reg[ch] <= 1'b1;
        end
        // channel reset holds port-not-ready for one cycle and idles the channel
        reset_busy_reg[ch] <= wr_cmd[ch] & i_wdata[`CMD_RESET];
        // start: idle -> engaged, engaged with pipeline loaded -> pipeline full
        if (start_ok[ch] && control_reg[ch][`CTL_MODE_HI:`CTL_MODE_LO] != `MODE_RESERVED) begin
          if (!engaged_reg[ch]) begin
            eng_n = 1'b1;
            halt_reg[ch] <= 1'b0;
          end else if (pipe_loaded_reg[ch] || i_wdata[`CMD_LOAD]) begin
            // a load and a start in one write count as a loaded pipeline
            pf_n = 1'b1;
          end
        end
        if (start_bad[ch]) begin
          pipe_bad_reg[ch] <= 1'b1;
        end
        // end of block: halt on parity or refused start, else chain to pipelined transfer if one is full
        if (i_block_end[ch] && engaged_reg[ch]) begin
          if (pipe_full_reg[ch] && !halt_reg[ch] && !pipe_bad_reg[ch]) begin
            pf_n = 1'b0;
          end else begin
            eng_n = 1'b0;
            pf_n = 1'b0;
            o_pipe_discard[ch] <= pipe_full_reg[ch] | pipe_bad_reg[ch];
            pipe_bad_reg[ch] <= 1'b0;
          end
          pipe_loaded_reg[ch] <= 1'b0;
        end
        // stop or reset forces idle
        if (wr_cmd[ch] && (i_wdata[`CMD_STOP] || i_wdata[`CMD_RESET])) begin
          eng_n = 1'b0;
          pf_n = 1'b0;
          pipe_loaded_reg[ch] <= 1'b0;
          pipe_bad_reg[ch] <= 1'b0;
          halt_reg[ch] <= 1'b0;
        end
        if (i_parity_err[ch] && engaged_reg[ch]) begin
          halt_reg[ch] <= 1'b1;
        end
        engaged_reg[ch] <= eng_n;
        pipe_full_reg[ch] <= pf_n;
        // programmed i/o tracking
        if (i_pio_req[ch] && !is_slave[ch]) begin
          port_pending_reg[ch] <= 1'b1;
          o_pio_grant[ch] <= 1'b1;
        end else if (i_pio_done[ch]) begin
          port_pending_reg[ch] <= 1'b0;
        end
        // disk go-ahead: raise while a request stands and the gate allows, drop when request ends
        req_seen_reg[ch] <= lreq[ch];
        if (!disk_mode[ch] || !lreq[ch]) begin
          goahead_reg[ch] <= 1'b0;
        end else if (gate[ch]) begin
          goahead_reg[ch] <= 1'b1;
        end
        // write-one clear first, then events set
        if (wr_irq[ch]) begin
          nxt = nxt & ~i_wdata[6:0];
        end
        if (control_reg[ch][`CTL_ENGAGED_IE] && engaged_reg[ch] && !eng_n) begin
          nxt[`IS_IDLE] = 1'b1;
        end
        if (control_reg[ch][`CTL_PIPE_IE] && pipe_full_reg[ch] && !pf_n) begin
          nxt[`IS_PIPE_FREE] = 1'b1;
        end
        if (i_parity_err[ch]) begin
          nxt[`IS_PARITY] = 1'b1;
        end
        if (i_fifo_overrun[ch] && !control_reg[ch][`CTL_PAUSE]) begin
          nxt[`IS_LATE] = 1'b1;
        end
        if (start_bad[ch]) begin
          nxt[`IS_START_REF] = 1'b1;
        end
        if (pio_bad[ch] || ctl_bad[ch]) begin
          nxt[`IS_PIO_REF] = 1'b1;
        end
        if (i_pio_parity[ch]) begin
          nxt[`IS_PIO_PAR] = 1'b1;
        end
        irq_reg[ch] <= nxt;
      end
    end
  end

  // pin drive: request output in plain slave modes, ack output in disk mode
  // strobes are never driven here; the outside master owns them in plain slave modes, the formatter in disk mode
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_transfer_request_pin <= 2'b00;
      o_transfer_request_oe <= 2'b00;
      o_transfer_ack_pin <= 2'b00;
      o_transfer_ack_oe <= 2'b00;
    end else begin
      // defaults first so each mode releases the pins it does not drive
      for (cp = 0; cp < 2; cp = cp + 1) begin
        o_transfer_request_pin[cp] <= 1'b0;
        o_transfer_request_oe[cp] <= 1'b0;
        o_transfer_ack_pin[cp] <= 1'b0;
        o_transfer_ack_oe[cp] <= 1'b0;
        case (control_reg[cp][`CTL_MODE_HI:`CTL_MODE_LO])
          `MODE_SINGLE_SLAVE: begin
            // one request per byte; drop while the master acks it
            o_transfer_request_oe[cp] <= 1'b1;
            o_transfer_request_pin[cp] <= engaged_reg[cp] & ~i_fifo_full[cp] &
                                          ~i_transfer_ack_pin[cp];
          end
          `MODE_BURST_SLAVE: begin
            // held through bytes, dropped only when fifo cannot accept
            o_transfer_request_oe[cp] <= 1'b1;
            o_transfer_request_pin[cp] <= engaged_reg[cp] & ~i_fifo_full[cp];
          end
          `MODE_DISK_SLAVE: begin
            // the formatter owns the strobes; only the go-ahead is ours
            o_transfer_ack_oe[cp] <= 1'b1;
            o_transfer_ack_pin[cp] <= goahead_reg[cp];
          end
          default: begin
            // reserved and master modes: pins idle
            o_transfer_request_oe[cp] <= 1'b0;
          end
        endcase
      end
    end
  end

  // register read, answered the cycle after the strobe; unmapped reads give zero
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_rdata <= `ZERO_BYTE;
    end else if (!i_rd) begin
      o_rdata <= `ZERO_BYTE;
    end else if (i_addr == `A_STATUS_ADDR) begin
      o_rdata <= status_byte(engaged_reg[0], pipe_full_reg[0], i_fifo_empty[0],
                             port_pending_reg[0] | reset_busy_reg[0], lreq[0],
                             ack_state[0]);
    end else if (i_addr == `B_STATUS_ADDR) begin
      o_rdata <= status_byte(engaged_reg[1], pipe_full_reg[1], i_fifo_empty[1],
                             port_pending_reg[1] | reset_busy_reg[1], lreq[1],
                             ack_state[1]);
    end else if (i_addr == `A_IRQ_STATUS_ADDR) begin
      o_rdata <= {any_fault(irq_reg[0]), irq_reg[0]};
    end else if (i_addr == `B_IRQ_STATUS_ADDR) begin
      o_rdata <= {any_fault(irq_reg[1]), irq_reg[1]};
    end else if (i_addr == `A_CONTROL_ADDR) begin
      o_rdata <= control_reg[0];
    end else if (i_addr == `B_CONTROL_ADDR) begin
      o_rdata <= control_reg[1];
    end else begin
      o_rdata <= `ZERO_BYTE;
    end
  end

endmodule

// ---- include/dma_chan_defs.vh ----
// register offsets, bit positions, mode codes and reset values for the dual slave dma channels
// assumed included by the single design file; definitions only
`ifndef DMA_CHAN_DEFS_VH
`define DMA_CHAN_DEFS_VH

// register byte offsets (8-bit address space)
`define A_STATUS_ADDR 8'h44
`define A_IRQ_STATUS_ADDR 8'h46
`define A_CONTROL_ADDR 8'h40
`define A_PIPE_ADDR 8'h42
`define B_STATUS_ADDR 8'hC4
`define B_IRQ_STATUS_ADDR 8'hC6
`define B_CONTROL_ADDR 8'hC0
`define B_PIPE_ADDR 8'hC2

// port mode codes (slave, burst, disk)
`define MODE_SINGLE_SLAVE 3'h4
`define MODE_RESERVED 3'h5
`define MODE_BURST_SLAVE 3'h6
`define MODE_DISK_SLAVE 3'h7

// control register fields
`define CTL_ENGAGED_IE 0
`define CTL_PIPE_IE 1
`define CTL_PAUSE 2
`define CTL_REQ_POL 3
`define CTL_MODE_LO 5
`define CTL_MODE_HI 7

// pipe/command register fields
`define CMD_START 0
`define CMD_STOP 1
`define CMD_LOAD 2
`define CMD_RESET 3

// status register bits
`define ST_ENGAGED 0
`define ST_PIPE_FULL 1
`define ST_FIFO_VACANT 2
`define ST_PORT_PENDING 3
`define ST_REQ_STATE 4
`define ST_ACK_STATE 5

// interrupt status bits
`define IS_IDLE 0
`define IS_PIPE_FREE 1
`define IS_PARITY 2
`define IS_LATE 3
`define IS_START_REF 4
`define IS_PIO_REF 5
`define IS_PIO_PAR 6
`define IS_ANY 7

`define CONTROL_RESET 8'h80
`define ZERO_BYTE 8'h00
`define LOW_MASK 8'h7F

`endif

// ---- bench/dma_chan_properties.sv ----
// concurrent checks on the pins and register port of the dual slave dma channels
// assumes one clock and a synchronous active-low reset; sees top ports only
`timescale 1ns/10ps
module dma_chan_properties (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [1:0] i_fifo_full,
  input wire [1:0] i_fifo_empty,
  input wire [1:0] i_pio_req,
  input wire [1:0] i_block_end,
  input wire [1:0] o_transfer_request_pin,
  input wire [1:0] o_transfer_request_oe,
  input wire [1:0] o_transfer_ack_pin,
  input wire [1:0] o_transfer_ack_oe,
  input wire [1:0] o_pio_grant,
  input wire [1:0] o_pipe_discard
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // read data must be quiet outside its one-cycle slot
  rd_quiet_a:
    assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata outside slot");
  // holes in the map read as zero
  rd_unmapped_a:
    assert property ($past(i_rd && (i_addr[6:0] < 7'h40 || i_addr[6:0] > 7'h46 || i_addr[0]))
      |-> o_rdata == 8'h00) else $error("unmapped read not zero");
  // fifo empty flag is live at the read edge
  fifo_flag_a:
    assert property ($past(i_rd && i_addr == 8'h44) |-> o_rdata[2] == $past(i_fifo_empty[0]))
      else $error("channel a fifo flag wrong");
  fifo_flag_b_a:
    assert property ($past(i_rd && i_addr == 8'hC4) |-> o_rdata[2] == $past(i_fifo_empty[1]))
      else $error("channel b fifo flag wrong");
  any_fault_a:
    assert property ($past(i_rd && i_addr[6:0] == 7'h46) |-> o_rdata[7] == |o_rdata[6:2])
      else $error("summary bit not or of faults");
  // a request level only goes out while the pin is an output
  req_drive_a:
    assert property (!(|(o_transfer_request_pin & ~o_transfer_request_oe)))
      else $error("request driven while input");
  req_full_a:
    assert property (o_transfer_request_pin[0] |-> !$past(i_fifo_full[0]))
      else $error("request held with fifo full");
  ack_drive_a:
    assert property (!(|(o_transfer_ack_pin & ~o_transfer_ack_oe)))
      else $error("go-ahead driven while input");
  pio_grant_a:
    assert property (o_pio_grant[0] |-> $past(i_pio_req[0])) else $error("grant without request");
  discard_a:
    assert property (o_pipe_discard[0] |-> $past(i_block_end[0]))
      else $error("discard away from block end");
  cover property (o_pipe_discard[0]);
  cover property (o_transfer_ack_pin[1]);
  cover property (o_transfer_request_pin[0] ##1 !o_transfer_request_pin[0]);
endmodule

bind dma_slave_channels dma_chan_properties chk_u (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_fifo_full(i_fifo_full), .i_fifo_empty(i_fifo_empty),
  .i_pio_req(i_pio_req), .i_block_end(i_block_end),
  .o_transfer_request_pin(o_transfer_request_pin),
  .o_transfer_request_oe(o_transfer_request_oe), .o_transfer_ack_pin(o_transfer_ack_pin),
  .o_transfer_ack_oe(o_transfer_ack_oe), .o_pio_grant(o_pio_grant),
  .o_pipe_discard(o_pipe_discard)
);

// ---- bench/far_master.sv ----
// host dma master and disk formatter facing both channels' request and ack pins
// assumes the bench raises i_want to make the formatter ask for bursts
`timescale 1ns/10ps
module far_master (
  input wire i_core_clk,
  input wire [1:0] i_want,
  input wire [1:0] i_req_drv,
  input wire [1:0] i_req_oe,
  input wire [1:0] i_ack_drv,
  input wire [1:0] i_ack_oe,
  output wire [1:0] o_req_lvl,
  output wire [1:0] o_ack_lvl
);
  reg [1:0] ack_reg = 2'h0; // master ack; the master also owns the data strobes
  reg [1:0] breq_reg = 2'h0; // formatter burst request
  // ack each request for one cycle; formatter drops its request on go-ahead
  always @(posedge i_core_clk) begin
    ack_reg <= i_req_oe & i_req_drv & ~ack_reg;
    breq_reg <= i_want & ~(i_ack_oe & i_ack_drv);
  end
  // resolve each wire from its driver; undriven lines sit pulled low
  assign o_req_lvl = (i_req_oe & i_req_drv) | (~i_req_oe & breq_reg);
  assign o_ack_lvl = (i_ack_oe & i_ack_drv) | (~i_ack_oe & ack_reg);
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the dual slave dma channels with a far-side master model
// assumes registered read data one cycle after the read strobe
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
  mismatches = mismatches + 1; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  reg i_core_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [1:0] want = 2'h0, full = 2'h0, emp = 2'h3, ovr = 2'h0, par = 2'h0;
  reg [1:0] bend = 2'h0, cdone = 2'h0, dread = 2'h0, pioq = 2'h0, piop = 2'h0;
  reg [1:0] pdone = 2'h0;
  wire [7:0] o_rdata;
  wire [1:0] rq_drv, rq_oe, ak_drv, ak_oe, rq_lvl, ak_lvl, disc, grant;
  integer mismatches = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  reg [3:0] hi;
  // rows: event kind (7 none), address read, value expected
  localparam bit [19:0] rows [0:10] = '{20'h74080, 20'h74200, 20'h74404, 20'h74600,
    20'h7C404, 20'h7C600, 20'h71000, 20'h04688, 20'h14684, 20'h246A0, 20'h346C0};
  dma_slave_channels dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_transfer_request_pin(rq_lvl), .o_transfer_request_pin(rq_drv),
    .o_transfer_request_oe(rq_oe), .i_transfer_ack_pin(ak_lvl), .o_transfer_ack_pin(ak_drv),
    .o_transfer_ack_oe(ak_oe), .i_fifo_full(full), .i_fifo_empty(emp), .i_fifo_overrun(ovr),
    .i_parity_err(par), .i_block_end(bend), .i_count_done(cdone), .i_disk_read(dread),
    .i_pio_req(pioq), .i_pio_done(pdone), .i_pio_parity(piop), .o_pio_grant(grant),
    .o_pipe_discard(disc));
  far_master far_u (.i_core_clk(i_core_clk), .i_want(want), .i_req_drv(rq_drv),
    .i_req_oe(rq_oe), .i_ack_drv(ak_drv), .i_ack_oe(ak_oe), .o_req_lvl(rq_lvl),
    .o_ack_lvl(ak_lvl));
  // 100 MHz clock
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  // hang guard: the run needs well under a thousand cycles
  always @(posedge i_core_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // one-cycle register write
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
    end
  endtask
  // read and compare in the single cycle the data stands
  task rc(input [7:0] a, input [7:0] e);
    begin
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      `CHK("rdata", e, o_rdata)
    end
  endtask
  // one-cycle event pulse on the chosen channels
  task hit(input [1:0] ch, input [3:0] k);
    begin
      @(posedge i_core_clk);
      case (k)
        0: ovr <= ch;
        1: par <= ch;
        2: pioq <= ch;
        3: piop <= ch;
        5: pdone <= ch;
        default: bend <= ch;
      endcase
      @(posedge i_core_clk);
      {ovr, par, pioq, piop, bend, pdone} <= 12'h000;
    end
  endtask
  // watch channel b go-ahead for a bounded window
  task ga(input e);
    reg s;
    begin
      s = 1'b0;
      repeat (12) begin
        @(posedge i_core_clk);
        #1;
        if (ak_drv[1] === 1'b1) s = 1'b1;
      end
      `CHK("go_ahead", e, s)
    end
  endtask
  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      if (rows[i][19:16] != 4'h7) hit(2'h1, rows[i][19:16]);
      rc(rows[i][15:8], rows[i][7:0]);
      if (rows[i][19:16] != 4'h7) wr(8'h46, 8'hFF);
    end
    wr(8'h40, 8'h84);
    hit(2'h1, 4'h0);
    rc(8'h46, 8'h00);
    // reserved mode must not start anything
    wr(8'h40, 8'hA0);
    wr(8'h42, 8'h01);
    rc(8'h44, 8'h04);
    `CHK("req_oe", 1'b0, rq_oe[0])
    // single slave: request toggles against the master's acks
    wr(8'h40, 8'h83);
    wr(8'h42, 8'h01);
    rc(8'h44, 8'h15);
    hi = 4'h0;
    repeat (8) begin
      @(posedge i_core_clk);
      #1;
      hi = hi + rq_drv[0];
    end
    `CHK("req_toggle", 1'b1, hi != 4'h0 && hi != 4'h8)
    wr(8'h40, 8'h80);
    rc(8'h46, 8'hA0);
    rc(8'h40, 8'h83);
    wr(8'h46, 8'hFF);
    wr(8'h42, 8'h05);
    rc(8'h44, 8'h07);
    wr(8'h42, 8'h01);
    rc(8'h46, 8'h90);
    hit(2'h1, 4'h4);
    #1;
    `CHK("discard", 1'b1, disc[0])
    rc(8'h46, 8'h93);
    rc(8'h44, 8'h04);
    wr(8'h46, 8'hFF);
    // burst slave: request stays up through acks until the fifo fills
    wr(8'h40, 8'hC0);
    wr(8'h42, 8'h01);
    repeat (3) @(posedge i_core_clk);
    hi = 4'h0;
    repeat (6) begin
      @(posedge i_core_clk);
      #1;
      hi = hi + rq_drv[0];
    end
    `CHK("burst_req", 4'h6, hi)
    full <= 2'h1;
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK("req_full", 1'b0, rq_drv[0])
    full <= 2'h0;
    hit(2'h1, 4'h4);
    // disk mode on channel b while formatter reads the disk
    wr(8'hC0, 8'hE0);
    wr(8'hC2, 8'h01);
    dread <= 2'h2;
    want <= 2'h2;
    ga(1'b1);
    `CHK("ack_oe", 1'b1, ak_oe[1])
    cdone <= 2'h2;
    repeat (4) @(posedge i_core_clk);
    ga(1'b0);
    rc(8'hC4, 8'h15);
    // formatter writes: go-ahead waits for fifo data
    dread <= 2'h0;
    ga(1'b0);
    emp <= 2'h1;
    ga(1'b1);
    hit(2'h2, 4'h1);
    repeat (4) @(posedge i_core_clk);
    ga(1'b0);
    rc(8'hC6, 8'h84);
    rc(8'h46, 8'h00);
    hit(2'h2, 4'h4);
    wr(8'hC6, 8'hFF);
    wr(8'hC2, 8'h01);
    ga(1'b1);
    want <= 2'h0;
    // master mode on channel a: pio accepted, pending until done
    wr(8'h40, 8'h00);
    hit(2'h1, 4'h2);
    #1;
    `CHK("pio_grant", 2'h1, grant)
    rc(8'h44, 8'h0C);
    hit(2'h1, 4'h5);
    rc(8'h44, 8'h04);
    // reset in mid-run restores the control default
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rc(8'h40, 8'h80);
    conclude;
  end
endmodule
